// ==== src/cwd_config_decoder.sv ====
// Configuration word decoder: fetches the two configuration words from flash
// after every reset, keeps shadow copies and decodes them into settings.
// Assumes a flash read port that answers each request with a valid pulse and
// an Avalon-MM master for the register view; all inputs are on CLK.
`timescale 1ns/100ps

// Summary of operation
// - After power-on reset, copy both flash words into shadows; settings decode shadows.
// - Bits 23 to 16 of each word always read back as one.
// - Without motor PWM, PWM lock, pin mode and polarity bits read one.
// - Code protect bit one leaves memory open; zero protects all program memory.
// - Write protect bit one keeps user memory writable; zero protects it.
// - Two-speed start runs fast RC until selected source ready, else selected directly.
// - PWM lock one requires key sequence for PWM writes; zero allows free writes.
// - Window field 11/10/01/00 gives 24, 37.5, 50, 75 percent open window.
// - Oscillator select three-bit code picks one of seven sources; 110 reserved.
// - Clock switch field 1x off, 01 switching only, 00 switching plus monitor.
// - Pin-select bit one allows one remap; zero allows unlimited remaps.
// - Outside crystal modes, second oscillator pin is clock out or GPIO.
// - Primary mode 11 off, 10 high-speed crystal, 01 medium crystal, 00 external.
// - Hard watchdog enable runs watchdog always; soft clear ignored; RC kept on.
// - Hard enable zero gives software control; clearing soft enable may stop RC.
// - Window disable one gives non-window mode; zero gives window mode.
// - Second oscillator pin function bit resets to factory value zero; the flash fetch overwrites it.
// - Configuration reloads from flash on every device reset kind.
module cwd_config_decoder #(
	parameter bit HAS_MOTOR_PWM = 1'b1
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic ARST_N,
	// Device reset request other than power-on, one-cycle pulse
	input wire logic DEV_RESET,
	// Flash read port
	output logic FLASH_REQ,
	output logic [15:0] FLASH_INDEX,
	input wire logic FLASH_VALID,
	input wire logic [cwd_pkg::CWD_WORD_W-1:0] FLASH_DATA,
	// Oscillator readiness from the clock block
	input wire logic SEL_SRC_READY,
	// Avalon-MM slave
	input wire logic [cwd_pkg::CWD_ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// Decoded settings
	output cwd_pkg::cwd_settings_t SETTINGS,
	output logic SETTINGS_VALID,
	output logic START_ON_FRC
);
	import cwd_pkg::*;

	typedef enum logic [1:0] {
		CWD_LD_SECONDARY,
		CWD_LD_PRIMARY,
		CWD_LD_RUN
	} cwd_load_t;

	cwd_load_t load_q;
	logic [CWD_WORD_W-1:0] sec_q;
	logic [CWD_WORD_W-1:0] pri_q;
	logic [CWD_WORD_W-1:0] fetched;
	logic soft_wdt_q;
	logic start_frc_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic [15:0] bus_index;
	logic bus_aligned;
	logic bus_req;
	logic rsvd_err;
	cwd_settings_t dec;

	// Force the unimplemented byte, and the PWM bits on variants without PWM
	always_comb begin
		fetched = FLASH_DATA;
		fetched[CWD_WORD_W-1:CWD_UNIMPL_LSB] = CWD_UNIMPL_ONES;
		if (!HAS_MOTOR_PWM) begin
			if (load_q == CWD_LD_SECONDARY) begin
				fetched[CWD_S_PWM_LOCK] = 1'b1;
				fetched[CWD_S_PWM_PIN] = 1'b1;
				fetched[CWD_S_PWM_PWM_LOW_SIDE_POLARITY] = 1'b1;
			end else begin
				fetched[CWD_P_PWM_PWM_HIGH_SIDE_POLARITY] = 1'b1;
			end
		end
	end

	// Load sequence; any device reset restarts it
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			load_q <= CWD_LD_SECONDARY;
		end else if (DEV_RESET) begin
			load_q <= CWD_LD_SECONDARY;
		end else begin
			unique case (load_q)
				CWD_LD_SECONDARY: begin
					if (FLASH_VALID) begin
						load_q <= CWD_LD_PRIMARY;
					end
				end
				CWD_LD_PRIMARY: begin
					if (FLASH_VALID) begin
						load_q <= CWD_LD_RUN;
					end
				end
				CWD_LD_RUN: begin
					load_q <= CWD_LD_RUN;
				end
			endcase
		end
	end

	// Shadow copies only change from the flash fetch
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			sec_q <= CWD_SEC_RESET;
			pri_q <= CWD_PRI_RESET;
		end else if (FLASH_VALID && !DEV_RESET) begin
			if (load_q == CWD_LD_SECONDARY) begin
				sec_q <= fetched;
			end else if (load_q == CWD_LD_PRIMARY) begin
				pri_q <= fetched;
			end
		end
	end

	always_comb begin
		FLASH_REQ = (load_q != CWD_LD_RUN) && !DEV_RESET;
		FLASH_INDEX = (load_q == CWD_LD_PRIMARY) ? CWD_IDX_PRIMARY : CWD_IDX_SECONDARY;
		SETTINGS_VALID = (load_q == CWD_LD_RUN);
	end

	// Reserved bits the programmer must set up; flagged, not corrected
	assign rsvd_err = pri_q[CWD_P_RSVD_HI] || pri_q[CWD_P_RSVD_LO]
		|| !pri_q[CWD_P_RSVD_TOOL];

	// Field decode
	always_comb begin
		dec = '0;
		dec.code_protect_en = !pri_q[CWD_P_CODE_PROT];
		dec.write_protect_en = !pri_q[CWD_P_WRITE_PROT];
		dec.two_speed_startup = sec_q[CWD_S_TWO_SPEED];
		dec.pwm_key_required = sec_q[CWD_S_PWM_LOCK];
		dec.pwm_pin_reset_mode = sec_q[CWD_S_PWM_PIN];
		dec.pwm_high_side_polarity = pri_q[CWD_P_PWM_PWM_HIGH_SIDE_POLARITY];
		dec.pwm_low_side_polarity = sec_q[CWD_S_PWM_PWM_LOW_SIDE_POLARITY];
		unique case (sec_q[CWD_S_WIN_LSB +: 2])
			2'h3: dec.watchdog_window_tenths = CWD_WIN_24;
			2'h2: dec.watchdog_window_tenths = CWD_WIN_37_5;
			2'h1: dec.watchdog_window_tenths = CWD_WIN_50;
			2'h0: dec.watchdog_window_tenths = CWD_WIN_75;
		endcase
		dec.osc_source = cwd_osc_t'(sec_q[CWD_S_OSC_LSB +: 3]);
		dec.osc_source_valid = (dec.osc_source != CWD_SRC_INVALID);
		dec.clock_switch_en = !sec_q[CWD_S_CKSM_LSB + 1];
		dec.fail_safe_monitor_en = (sec_q[CWD_S_CKSM_LSB +: 2] == 2'h0);
		dec.pin_select_single_config = sec_q[CWD_S_PIN_ONCE];
		dec.primary_osc_mode = cwd_posc_t'(sec_q[CWD_S_POSC_LSB +: 2]);
		// Crystal modes own the pin, so neither function applies there
		if (dec.primary_osc_mode != CWD_POSC_MEDIUM_XTAL
				&& dec.primary_osc_mode != CWD_POSC_HIGH_XTAL) begin
			dec.second_osc_pin_clock_out = sec_q[CWD_S_OSC_PIN_FN];
			dec.second_osc_pin_gpio = !sec_q[CWD_S_OSC_PIN_FN];
		end
		if (pri_q[CWD_P_WDT_HARD]) begin
			dec.watchdog_run = 1'b1;
			dec.low_power_rc_osc_may_stop = 1'b0;
			dec.soft_enable_ignored = 1'b1;
		end else begin
			dec.watchdog_run = soft_wdt_q;
			dec.low_power_rc_osc_may_stop = !soft_wdt_q;
			dec.soft_enable_ignored = 1'b0;
		end
		dec.watchdog_windowed = !pri_q[CWD_P_WDT_WATCHDOG_WINDOW_DISABLE];
	end

	// Reserved source code drives no selection at all
	always_comb begin
		SETTINGS = dec;
		if (!dec.osc_source_valid) begin
			SETTINGS.osc_source = CWD_SRC_INVALID;
		end
	end

	// Two-speed start: stay on fast RC until the selected source is ready
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			start_frc_q <= 1'b1;
		end else if (DEV_RESET || load_q != CWD_LD_RUN) begin
			start_frc_q <= 1'b1;
		end else if (!dec.two_speed_startup || SEL_SRC_READY) begin
			start_frc_q <= 1'b0;
		end
	end

	assign START_ON_FRC = start_frc_q && dec.two_speed_startup && SETTINGS_VALID;

	// Register bus: one wait cycle, then the answer from flops
	assign bus_req = AVS_READ || AVS_WRITE;
	assign bus_index = AVS_ADDRESS[17:2];
	assign bus_aligned = (AVS_ADDRESS[1:0] == 2'h0);
	// Loading stalls the bus so a read never sees half-loaded shadows
	assign AVS_WAITREQUEST = bus_req && !ack_q;
	assign AVS_READDATA = rdata_q;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ack_q <= 1'b0;
		end else if (ack_q) begin
			ack_q <= 1'b0;
		end else begin
			// A reload request must not complete a transfer against shadows about to change
			ack_q <= bus_req && (load_q == CWD_LD_RUN) && !DEV_RESET;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rdata_q <= 32'h0000_0000;
		end else if (AVS_READ && !ack_q && load_q == CWD_LD_RUN && !DEV_RESET) begin
			rdata_q <= 32'h0000_0000;
			if (bus_aligned) begin
				unique case (bus_index)
					CWD_IDX_SECONDARY: rdata_q[CWD_WORD_W-1:0] <= sec_q;
					CWD_IDX_PRIMARY: rdata_q[CWD_WORD_W-1:0] <= pri_q;
					CWD_IDX_STATUS: begin
						rdata_q[CWD_ST_LOADED] <= 1'b1;
						rdata_q[CWD_ST_RSVD_ERR] <= rsvd_err;
						rdata_q[CWD_ST_OSC_INVALID] <= !dec.osc_source_valid;
						rdata_q[CWD_ST_ON_SELECTED] <= !START_ON_FRC;
					end
					CWD_IDX_CONTROL: rdata_q[CWD_CT_SOFT_WDT] <= soft_wdt_q;
					default: rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Software watchdog enable; the only writable bit, shadows stay read-only
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			soft_wdt_q <= CWD_SOFT_WDT_RESET;
		end else if (DEV_RESET) begin
			soft_wdt_q <= CWD_SOFT_WDT_RESET;
		end else if (AVS_WRITE && ack_q && bus_aligned && AVS_BYTEENABLE[0]
				&& bus_index == CWD_IDX_CONTROL) begin
			soft_wdt_q <= AVS_WRITEDATA[CWD_CT_SOFT_WDT];
		end
	end

endmodule : cwd_config_decoder

// ==== src/cwd_pkg.sv ====
// Package for the configuration word decoder: word offsets, field positions,
// reset values and the decoded settings carrier.
// Assumes one 200 MHz clock domain and a byte-addressed 32-bit register bus.
package cwd_pkg;

	// Printed word offsets, kept as register indexes; byte address is four times
	localparam logic [15:0] CWD_IDX_SECONDARY = 16'h57FC;
	localparam logic [15:0] CWD_IDX_PRIMARY = 16'h57FE;
	localparam logic [15:0] CWD_IDX_STATUS = 16'h5800;
	localparam logic [15:0] CWD_IDX_CONTROL = 16'h5801;

	localparam int CWD_ADDR_W = 18;
	localparam int CWD_WORD_W = 24;

	// Secondary word field positions
	localparam int CWD_S_TWO_SPEED = 15;
	localparam int CWD_S_PWM_LOCK = 14;
	localparam int CWD_S_PWM_PIN = 13;
	localparam int CWD_S_WIN_LSB = 11;
	localparam int CWD_S_OSC_LSB = 8;
	localparam int CWD_S_CKSM_LSB = 6;
	localparam int CWD_S_OSC_PIN_FN = 5;
	localparam int CWD_S_PIN_ONCE = 4;
	localparam int CWD_S_PWM_PWM_LOW_SIDE_POLARITY = 3;
	localparam int CWD_S_POSC_LSB = 0;

	// Primary word field positions
	localparam int CWD_P_RSVD_HI = 15;
	localparam int CWD_P_RSVD_LO = 14;
	localparam int CWD_P_CODE_PROT = 13;
	localparam int CWD_P_WRITE_PROT = 12;
	localparam int CWD_P_RSVD_TOOL = 11;
	localparam int CWD_P_PWM_PWM_HIGH_SIDE_POLARITY = 10;
	localparam int CWD_P_WDT_HARD = 7;
	localparam int CWD_P_WDT_WATCHDOG_WINDOW_DISABLE = 6;

	// Unimplemented upper byte
	localparam int CWD_UNIMPL_LSB = 16;
	localparam logic [7:0] CWD_UNIMPL_ONES = 8'hFF;

	// Shadow reset values: unprogrammed ones, clock-out pin bit factory zero
	localparam logic [23:0] CWD_SEC_RESET = 24'hFFFFDF;
	localparam logic [23:0] CWD_PRI_RESET = 24'hFFFFFF;

	// Status and control bit positions
	localparam int CWD_ST_LOADED = 0;
	localparam int CWD_ST_RSVD_ERR = 1;
	localparam int CWD_ST_OSC_INVALID = 2;
	localparam int CWD_ST_ON_SELECTED = 3;
	localparam int CWD_CT_SOFT_WDT = 0;
	localparam logic CWD_SOFT_WDT_RESET = 1'b0;

	// Window share in tenths of a percent
	localparam logic [9:0] CWD_WIN_24 = 10'd240;
	localparam logic [9:0] CWD_WIN_37_5 = 10'd375;
	localparam logic [9:0] CWD_WIN_50 = 10'd500;
	localparam logic [9:0] CWD_WIN_75 = 10'd750;

	typedef enum logic [2:0] {
		CWD_SRC_FRC = 3'h0,
		CWD_SRC_FRC_DIV_PLL = 3'h1,
		CWD_SRC_PRIMARY = 3'h2,
		CWD_SRC_PRIMARY_PLL = 3'h3,
		CWD_SRC_SECONDARY = 3'h4,
		CWD_SRC_LOW_POWER_RC_OSC = 3'h5,
		CWD_SRC_INVALID = 3'h6,
		CWD_SRC_FRC_DIV = 3'h7
	} cwd_osc_t;

	typedef enum logic [1:0] {
		CWD_POSC_EXT_CLOCK = 2'h0,
		CWD_POSC_MEDIUM_XTAL = 2'h1,
		CWD_POSC_HIGH_XTAL = 2'h2,
		CWD_POSC_DISABLED = 2'h3
	} cwd_posc_t;

	typedef struct packed {
		logic code_protect_en;
		logic write_protect_en;
		logic two_speed_startup;
		logic pwm_key_required;
		logic pwm_pin_reset_mode;
		logic pwm_high_side_polarity;
		logic pwm_low_side_polarity;
		logic [9:0] watchdog_window_tenths;
		cwd_osc_t osc_source;
		logic osc_source_valid;
		logic clock_switch_en;
		logic fail_safe_monitor_en;
		logic pin_select_single_config;
		logic second_osc_pin_clock_out;
		logic second_osc_pin_gpio;
		cwd_posc_t primary_osc_mode;
		logic watchdog_run;
		logic low_power_rc_osc_may_stop;
		logic soft_enable_ignored;
		logic watchdog_windowed;
	} cwd_settings_t;

endpackage : cwd_pkg

// ==== tb/cwd_config_decoder_assertions.sv ====
// Port checker for the configuration word decoder.
// Assumes binding into cwd_config_decoder; single CLK domain, async active-low reset.
`timescale 1ns/100ps
module cwd_checker import cwd_pkg::*; (
	// Clock and reset
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic DEV_RESET,
	// Flash port
	input wire logic FLASH_REQ,
	input wire logic [15:0] FLASH_INDEX,
	input wire logic FLASH_VALID,
	input wire logic [CWD_WORD_W-1:0] FLASH_DATA,
	// Bus and settings
	input wire logic [CWD_ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire cwd_settings_t SETTINGS,
	input wire logic SETTINGS_VALID
);
	logic [23:0] sec_q;
	logic [23:0] pri_q;
	// Own copy of the fetched words, so decode is judged against the flash traffic
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			sec_q <= CWD_SEC_RESET;
			pri_q <= CWD_PRI_RESET;
		end else if (FLASH_VALID && FLASH_REQ && !DEV_RESET) begin
			if (FLASH_INDEX == CWD_IDX_SECONDARY) sec_q <= FLASH_DATA;
			if (FLASH_INDEX == CWD_IDX_PRIMARY) pri_q <= FLASH_DATA;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	property p_prot;
		SETTINGS_VALID |-> SETTINGS.code_protect_en == !pri_q[13]
			&& SETTINGS.write_protect_en == !pri_q[12];
	endproperty
	a_prot: assert property (p_prot) else $error("protect decode wrong");
	property p_osc;
		SETTINGS_VALID |-> SETTINGS.osc_source_valid == (sec_q[10:8] != 3'h6);
	endproperty
	a_osc: assert property (p_osc) else $error("osc code validity wrong");
	property p_cksm;
		SETTINGS_VALID |-> SETTINGS.clock_switch_en == !sec_q[7]
			&& SETTINGS.fail_safe_monitor_en == (sec_q[7:6] == 2'h0);
	endproperty
	a_cksm: assert property (p_cksm) else $error("clock switch decode wrong");
	property p_wdt;
		SETTINGS_VALID && pri_q[7] |-> SETTINGS.watchdog_run
			&& SETTINGS.soft_enable_ignored && !SETTINGS.low_power_rc_osc_may_stop;
	endproperty
	a_wdt: assert property (p_wdt) else $error("hard watchdog not forced");
	property p_win;
		SETTINGS_VALID |-> SETTINGS.watchdog_windowed == !pri_q[6];
	endproperty
	a_win: assert property (p_win) else $error("window mode wrong");
	property p_pin;
		SETTINGS_VALID && !(^sec_q[1:0]) |-> SETTINGS.second_osc_pin_clock_out == sec_q[5]
			&& SETTINGS.second_osc_pin_gpio == !sec_q[5];
	endproperty
	a_pin: assert property (p_pin) else $error("osc pin function wrong");
	property p_hold;
		SETTINGS_VALID && $past(SETTINGS_VALID) |-> $stable(SETTINGS.osc_source)
			&& $stable(SETTINGS.watchdog_window_tenths);
	endproperty
	a_hold: assert property (p_hold) else $error("settings moved while loaded");
	property p_stall;
		!SETTINGS_VALID && AVS_READ |-> AVS_WAITREQUEST;
	endproperty
	a_stall: assert property (p_stall) else $error("read answered before load");
	property p_load;
		$rose(SETTINGS_VALID) |-> $past(FLASH_INDEX) == CWD_IDX_PRIMARY;
	endproperty
	a_load: assert property (p_load) else $error("load ended off primary word");
	property p_reload;
		DEV_RESET |=> !SETTINGS_VALID && FLASH_INDEX == CWD_IDX_SECONDARY;
	endproperty
	a_reload: assert property (p_reload) else $error("no reload on reset");
	property p_upper;
		AVS_READ && !AVS_WAITREQUEST && (AVS_ADDRESS == {CWD_IDX_SECONDARY, 2'h0}
			|| AVS_ADDRESS == {CWD_IDX_PRIMARY, 2'h0}) |-> AVS_READDATA[31:16] == 16'h00FF;
	endproperty
	a_upper: assert property (p_upper) else $error("upper byte not ones");
	c_load: cover property ($rose(SETTINGS_VALID));
	c_read: cover property (AVS_READ && !AVS_WAITREQUEST);
	c_reload: cover property (DEV_RESET);
endmodule : cwd_checker
bind cwd_config_decoder cwd_checker u_chk (
	.CLK(CLK),
	.ARST_N(ARST_N),
	.DEV_RESET(DEV_RESET),
	.FLASH_REQ(FLASH_REQ),
	.FLASH_INDEX(FLASH_INDEX),
	.FLASH_VALID(FLASH_VALID),
	.FLASH_DATA(FLASH_DATA),
	.AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ),
	.AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST),
	.SETTINGS(SETTINGS),
	.SETTINGS_VALID(SETTINGS_VALID)
);

// ==== tb/cwd_config_decoder_bench.sv ====
// Self-checking bench for the configuration word decoder.
// Assumes cwd_pkg and the design compiled first; the bench also plays the flash.
`timescale 1ns/100ps
module cwd_config_decoder_bench;
	import cwd_pkg::*;
	typedef struct {logic [31:0] e; logic [31:0] m;} cwd_note_t;
	logic CLK = 1'h0, ARST_N = 1'h0, DEV_RESET = 1'h0, FLASH_VALID = 1'h0, SEL_SRC_READY = 1'h0;
	logic AVS_READ = 1'h0, AVS_WRITE = 1'h0, FLASH_REQ, AVS_WAITREQUEST, SETTINGS_VALID, START_ON_FRC;
	logic [15:0] FLASH_INDEX;
	logic [23:0] FLASH_DATA = 24'h0, sec_w, pri_w;
	logic [17:0] AVS_ADDRESS = 18'h0;
	logic [3:0] AVS_BYTEENABLE = 4'hF;
	logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, lfsr = 32'h898F2FBE;
	cwd_settings_t SETTINGS, np_set;
	logic [3:0] np_pwm;
	cwd_note_t exp_q[$];
	int error_cnt = 0, n_compared = 0;
	localparam logic [17:0] A_SEC = {CWD_IDX_SECONDARY, 2'h0}, A_PRI = {CWD_IDX_PRIMARY, 2'h0};
	localparam logic [17:0] A_ST = {CWD_IDX_STATUS, 2'h0}, A_CT = {CWD_IDX_CONTROL, 2'h0};
	cwd_config_decoder dut (.CLK(CLK), .ARST_N(ARST_N), .DEV_RESET(DEV_RESET),
		.FLASH_REQ(FLASH_REQ), .FLASH_INDEX(FLASH_INDEX), .FLASH_VALID(FLASH_VALID),
		.FLASH_DATA(FLASH_DATA), .SEL_SRC_READY(SEL_SRC_READY),
		.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
		.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
		.SETTINGS(SETTINGS), .SETTINGS_VALID(SETTINGS_VALID), .START_ON_FRC(START_ON_FRC));
	// Variant without motor PWM, fed the same flash and bus traffic
	cwd_config_decoder #(.HAS_MOTOR_PWM(1'b0)) dut_np (.CLK(CLK), .ARST_N(ARST_N),
		.DEV_RESET(DEV_RESET), .FLASH_REQ(), .FLASH_INDEX(), .FLASH_VALID(FLASH_VALID),
		.FLASH_DATA(FLASH_DATA), .SEL_SRC_READY(SEL_SRC_READY),
		.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
		.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_READDATA(), .AVS_WAITREQUEST(), .SETTINGS(np_set), .SETTINGS_VALID(),
		.START_ON_FRC());
	assign np_pwm = {np_set.pwm_key_required, np_set.pwm_pin_reset_mode,
		np_set.pwm_high_side_polarity, np_set.pwm_low_side_polarity};
	initial begin
		forever #2.5 CLK = ~CLK;
	end
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Flash answers each request a cycle later; between answers the data bus is scrambled
	always @(posedge CLK) begin
		if (FLASH_REQ === 1'b1 && !FLASH_VALID) begin
			FLASH_VALID <= 1'b1;
			FLASH_DATA <= (FLASH_INDEX == CWD_IDX_PRIMARY) ? pri_w : sec_w;
		end else begin
			FLASH_VALID <= 1'b0;
			FLASH_DATA <= ~FLASH_DATA;
		end
	end
	// Every accepted read is judged against the oldest note
	always @(posedge CLK) begin
		if (AVS_READ && AVS_WAITREQUEST === 1'b0) begin
			chk("read data", AVS_READDATA & exp_q[0].m, exp_q[0].e);
			void'(exp_q.pop_front());
		end
	end
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nxt
	function automatic cwd_settings_t exp_set(input logic [23:0] s, input logic [23:0] p,
		input logic sw);
		logic x;
		logic [9:0] w;
		x = s[1:0] == 2'h1 || s[1:0] == 2'h2;
		w = s[12:11] == 2'h3 ? CWD_WIN_24 : s[12:11] == 2'h2 ? CWD_WIN_37_5 :
			s[12:11] == 2'h1 ? CWD_WIN_50 : CWD_WIN_75;
		return '{!p[13], !p[12], s[15], s[14], s[13], p[10], s[3], w, cwd_osc_t'(s[10:8]),
			s[10:8] != 3'h6, !s[7], s[7:6] == 2'h0, s[4], s[5] && !x, !s[5] && !x,
			cwd_posc_t'(s[1:0]), p[7] || sw, !p[7] && !sw, p[7], !p[6]};
	endfunction : exp_set
	// Bus cycle: request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [17:0] a, input logic [31:0] d);
		int i;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_READ <= !wr;
		AVS_WRITE <= wr;
		for (i = 0; i < 300; i++) begin
			@(posedge CLK);
			if (AVS_WAITREQUEST === 1'b0) break;
		end
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
		if (i == 300) begin
			error_cnt++;
			tally_and_finish();
		end
		@(posedge CLK);
	endtask : bus
	task automatic rd(input logic [17:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back('{e, m});
		bus(1'b0, a, 32'h0);
	endtask : rd
	initial begin
		for (int k = 0; k < 8; k++) begin
			lfsr = nxt(nxt(lfsr));
			// Every code of window, oscillator, switching and primary mode is visited
			sec_w = {8'h00, lfsr[15:13], k[1:0], k[2:0], k[1:0], lfsr[5:2], k[1:0]};
			// Reserved bits kept as the programmer must, except one deliberate violation
			pri_w = {8'h00, 1'b0, k == 5, lfsr[20:19], 1'b1, lfsr[26:24], k[2], lfsr[22:16]};
			SEL_SRC_READY <= 1'b0;
			if (k[0] || k == 0) begin
				ARST_N <= 1'b0;
				repeat (4) @(posedge CLK);
				ARST_N <= 1'b1;
			end else begin
				DEV_RESET <= 1'b1;
				@(posedge CLK);
				DEV_RESET <= 1'b0;
			end
			rd(A_ST, {29'h0, k == 6, k == 5, 1'b1}, 32'h7);
			chk("valid", SETTINGS_VALID, 32'h1);
			chk("start on fast rc", START_ON_FRC, sec_w[15]);
			chk("settings", SETTINGS, exp_set(sec_w, pri_w, 1'b0));
			chk("no pwm bits", np_pwm, 32'hF);
			SEL_SRC_READY <= 1'b1;
			bus(1'b1, A_SEC, lfsr);
			rd(A_SEC, {16'h00FF, sec_w[15:0]}, 32'hFFFFFFFF);
			rd(A_PRI, {16'h00FF, pri_w[15:0]}, 32'hFFFFFFFF);
			rd(18'h00100, 32'h0, 32'hFFFFFFFF);
			chk("start after ready", START_ON_FRC, 32'h0);
			bus(1'b1, A_CT, 32'h1);
			rd(A_CT, 32'h1, 32'h1);
			chk("settings soft", SETTINGS, exp_set(sec_w, pri_w, 1'b1));
			$display("test %0d done", k);
		end
		tally_and_finish();
	end
endmodule : cwd_config_decoder_bench
